/* File: core/abhp_pkg.sv */
/*
  package for the byte-wide converter host port: timing constants, control
  byte field positions and sequencer states.
  assumes a 40 MHz system clock; no other file defines these values.
*/
package abhp_pkg;
  // system clock
  localparam int unsigned CLK_SYS_HZ      = 40_000_000;
  // conversion length in converter clocks
  localparam int unsigned CONV_CLOCKS     = 13;
  // acquisition length in converter clocks (external clock)
  localparam int unsigned ACQ_CLOCKS      = 3;
  // internal acquisition time with the on-chip clock, in ns
  localparam int unsigned ACQ_INT_NS      = 1000;
  // that time in system cycles, rounded down, at least one
  localparam int unsigned ACQ_INT_CYC_RAW = (ACQ_INT_NS * (CLK_SYS_HZ / 1_000_000)) / 1000;
  localparam int unsigned ACQ_INT_CYCLES  = (ACQ_INT_CYC_RAW < 1) ? 1 : ACQ_INT_CYC_RAW;
  // on-chip converter clock divider ratio (system cycles per converter clock)
  localparam int unsigned ONCHIP_DIV      = 5;
  // widths
  localparam int unsigned RESULT_W        = 10;
  localparam int unsigned BUS_W           = 8;
  // position of the acquisition mode bit in the control byte
  localparam int unsigned ACQ_MODE_POS    = 5;
  // value of the done line after reset (inactive, high)
  localparam logic        DONE_RESET      = 1'b1;

  // sequencer states
  typedef enum logic [1:0] {
    ABHP_IDLE,
    ABHP_ACQ_EXT,
    ABHP_ACQ_INT,
    ABHP_CONV
  } abhp_state_type;
endpackage

/* File: core/abhp_port.sv */
/*
  byte-wide parallel host port of a 10-bit converter: strobe decoding,
  acquisition and conversion sequencing, done flag and result byte mux.
  assumes a 40 MHz system clock; all host pins are asynchronous and are
  synchronised here; result_in comes from the sar core on the same clock
  and is taken when the last converter clock of a conversion ends.
*/
`timescale 1ns/10ps
module abhp_port
  import abhp_pkg::*;
#(
  parameter int unsigned CONV_CNT = abhp_pkg::CONV_CLOCKS // converter clocks per conversion
) (
  input  wire logic                          clk_sys_in,        // 40 MHz system clock
  input  wire logic                          rst_b_in,          // async active-low reset
  input  wire logic                          cs_b_in,           // chip select, active low
  input  wire logic                          rd_b_in,           // read strobe, active low
  input  wire logic                          wr_b_in,           // write strobe, active low
  input  wire logic                          high_byte_select_in, // 1: upper two bits
  input  wire logic                          conv_clk_pin_in,   // external converter clock pin
  input  wire logic                          ext_clock_mode_in, // 1: use the clock pin
  input  wire logic [abhp_pkg::BUS_W-1:0]    data_in,           // bus level seen at the pins
  input  wire logic [abhp_pkg::RESULT_W-1:0] result_in,         // value from the sar core
  output logic      [abhp_pkg::BUS_W-1:0]    data_out,          // bus drive value
  output logic                               data_oe_b_out,     // low while driving the bus
  output logic                               done_b_out,        // done level, active low
  output logic                               done_oe_b_out,     // low while driving done
  output logic      [abhp_pkg::BUS_W-1:0]    control_byte_out,  // last latched control byte
  output logic                               sampling_out,      // track/hold in track
  output logic                               converting_out     // conversion running
);
  import abhp_pkg::*;

  initial begin
    if (CONV_CNT < 1 || CONV_CNT > 255) $error("abhp_port: CONV_CNT out of range");
  end

  // reset release: two flops so every flop leaves reset on the same edge
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire logic rst_b; // released reset used everywhere below

  assign rst_b = rst_sync_q;

  // every pin level passes two flops before use
  logic [2:0]       pins_s;   // synchronised strobes, preset to their idle high
  logic [1:0]       clks_s;   // synchronised clock pin and clock mode, preset low
  logic [BUS_W-1:0] data_s;   // synchronised bus
  abhp_sync #(.WIDTH(3), .RST_VAL(1'b1)) u_sync_ctl (
    .clk_in   (clk_sys_in),
    .rst_b_in (rst_b),
    .async_in ({cs_b_in, rd_b_in, wr_b_in}),
    .sync_out (pins_s)
  );
  // preset low like the clock edge history, so leaving reset makes no false fall
  abhp_sync #(.WIDTH(2), .RST_VAL(1'b0)) u_sync_clk (
    .clk_in   (clk_sys_in),
    .rst_b_in (rst_b),
    .async_in ({conv_clk_pin_in, ext_clock_mode_in}),
    .sync_out (clks_s)
  );
  abhp_sync #(.WIDTH(BUS_W), .RST_VAL(1'b0)) u_sync_dat (
    .clk_in   (clk_sys_in),
    .rst_b_in (rst_b),
    .async_in (data_in),
    .sync_out (data_s)
  );
  logic hbs_s; // high byte select, synchronised
  abhp_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_hbs (
    .clk_in   (clk_sys_in),
    .rst_b_in (rst_b),
    .async_in (high_byte_select_in),
    .sync_out (hbs_s)
  );

  wire logic cs_s;
  wire logic rd_s;
  wire logic wr_s;
  wire logic cclk_s;
  wire logic extclk_s;
  assign cs_s     = pins_s[2];
  assign rd_s     = pins_s[1];
  assign wr_s     = pins_s[0];
  assign cclk_s   = clks_s[1];
  assign extclk_s = clks_s[0];

  // edge history of synchronised strobes and clock pin
  logic rd_prev_q, rd_prev_d;
  logic wr_prev_q, wr_prev_d;
  logic cclk_prev_q, cclk_prev_d;
  logic [2:0] div_q, div_d; // on-chip clock divider

  // strobe events, qualified by chip select
  logic rd_fall;   // start of a read cycle
  logic wr_rise;   // end of a write pulse
  logic tick;      // one converter clock: falling edge of pin or divider
  always_comb begin
    rd_prev_d   = rd_s;
    wr_prev_d   = wr_s;
    cclk_prev_d = cclk_s;
    rd_fall     = !cs_s && rd_prev_q && !rd_s;
    wr_rise     = !cs_s && !wr_prev_q && wr_s;
    // on-chip clock is a divider enable; external clock counts pin falls
    div_d = (div_q == 3'(ONCHIP_DIV - 1)) ? 3'h0 : 3'(div_q + 3'h1);
    tick  = extclk_s ? (cclk_prev_q && !cclk_s) : (div_q == 3'h0);
  end

  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      rd_prev_q   <= 1'b1;
      wr_prev_q   <= 1'b1;
      cclk_prev_q <= 1'b0;
      div_q       <= 3'h0;
    end else begin
      rd_prev_q   <= rd_prev_d;
      wr_prev_q   <= wr_prev_d;
      cclk_prev_q <= cclk_prev_d;
      div_q       <= div_d;
    end
  end

  // sequencer: acquisition, conversion and the done flag
  abhp_state_type   state_q, state_d;
  logic [9:0]       cnt_q, cnt_d;     // clocks or system cycles left
  logic [BUS_W-1:0] ctl_q, ctl_d;     // latched control byte
  logic [RESULT_W-1:0] res_q, res_d;  // held result
  logic             done_q, done_d;   // done level, active low

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ctl_d   = ctl_q;
    res_d   = res_q;
    done_d  = done_q;
    // a read takes the done flag back high
    if (rd_fall) begin
      done_d = 1'b1;
    end
    case (state_q)
      ABHP_ACQ_EXT: begin
        // stays in track until the next write rise
        if (wr_rise) begin
          ctl_d   = data_s;
          done_d  = 1'b1;
          state_d = ABHP_CONV;
          cnt_d   = 10'(CONV_CNT);
        end
      end
      ABHP_ACQ_INT: begin
        // count three converter clocks, or 1 us of system time
        if (extclk_s ? tick : 1'b1) begin
          cnt_d = cnt_q - 10'h1;
          if (cnt_q == 10'h1) begin
            state_d = ABHP_CONV;
            cnt_d   = 10'(CONV_CNT);
          end
        end
      end
      ABHP_CONV: begin
        if (tick) begin
          cnt_d = cnt_q - 10'h1;
          if (cnt_q == 10'h1) begin
            state_d = ABHP_IDLE;
            res_d   = result_in;
            done_d  = 1'b0;
          end
        end
      end
      default: ; // idle: wait for a write
    endcase
    // a fresh control byte outside external track restarts acquisition,
    // aborting any conversion; its done clear wins over the conversion-end set above
    if (wr_rise && state_q != ABHP_ACQ_EXT) begin
      ctl_d  = data_s;
      done_d = 1'b1;
      if (data_s[ACQ_MODE_POS]) begin
        state_d = ABHP_ACQ_EXT;
      end else begin
        state_d = ABHP_ACQ_INT;
        cnt_d   = extclk_s ? 10'(ACQ_CLOCKS) : 10'(ACQ_INT_CYCLES);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ABHP_IDLE;
      cnt_q   <= 10'h000;
      ctl_q   <= 8'h00;
      res_q   <= 10'h000;
      done_q  <= DONE_RESET;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ctl_q   <= ctl_d;
      res_q   <= res_d;
      done_q  <= done_d;
    end
  end

  // pin drivers, all registered
  logic [BUS_W-1:0] dout_q, dout_d;
  logic dout_oe_q, dout_oe_d;
  logic done_oe_q, done_oe_d;
  logic samp_q, samp_d;
  logic conv_q, conv_d;
  always_comb begin
    // upper byte puts bit 9 on line 1 and bit 8 on line 0
    dout_d    = hbs_s ? {6'h00, res_q[9:8]} : res_q[7:0];
    // bus only while select and read are both low
    dout_oe_d = !(!cs_s && !rd_s);
    // done line floats while select is high
    done_oe_d = cs_s;
    samp_d    = (state_d == ABHP_ACQ_EXT) || (state_d == ABHP_ACQ_INT);
    conv_d    = (state_d == ABHP_CONV);
  end

  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      dout_q    <= 8'h00;
      dout_oe_q <= 1'b1;
      done_oe_q <= 1'b1;
      samp_q    <= 1'b0;
      conv_q    <= 1'b0;
    end else begin
      dout_q    <= dout_d;
      dout_oe_q <= dout_oe_d;
      done_oe_q <= done_oe_d;
      samp_q    <= samp_d;
      conv_q    <= conv_d;
    end
  end

  assign data_out         = dout_q;
  assign data_oe_b_out    = dout_oe_q;
  assign done_b_out       = done_q;
  assign done_oe_b_out    = done_oe_q;
  assign control_byte_out = ctl_q;
  assign sampling_out     = samp_q;
  assign converting_out   = conv_q;
endmodule

/* File: core/abhp_sync.sv */
/*
  two flip-flop synchroniser for a vector of asynchronous pin levels.
  assumes a single clock and an active-low async reset already released
  synchronously by the caller.
*/
`timescale 1ns/10ps
module abhp_sync #(
  parameter int unsigned WIDTH = 1,     // number of levels
  parameter logic        RST_VAL = 1'b1 // idle level of the pins
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q; // first stage, read only by the second
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q; // second stage
  logic [WIDTH-1:0] sync_d;

  initial begin
    if (WIDTH < 1) $error("abhp_sync: WIDTH must be at least 1");
  end

  // next values: plain shift
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // registers, preset to the idle pin level
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= {WIDTH{RST_VAL}};
      sync_q <= {WIDTH{RST_VAL}};
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

/* File: verif/abhp_host_model.sv */
/*
  host side model: converter clock pin and the shared data bus level.
  assumes the bench drives strobes; released bus shows the inverted last value.
*/
`timescale 1ns/10ps
module abhp_host_model (
  input  wire logic       ext_mode_in, // host supplies the clock pin
  input  wire logic       drv_oe_b_in, // port drives the bus when low
  input  wire logic [7:0] drv_in,      // port drive value
  input  wire logic       host_oe_in,  // host drives the bus
  input  wire logic [7:0] host_d_in,   // host drive value
  output logic            clk_pin_out, // converter clock pin
  output logic      [7:0] bus_out      // resolved bus level
);
  logic pin_q = 1'b0; // clock pin level, written by one process only
  // 160 ns pin clock in external mode, tied to ground otherwise
  always begin
    #80;
    pin_q = ext_mode_in ? ~pin_q : 1'b0;
  end
  assign clk_pin_out = pin_q;
  // nobody driving: inverted value, so a stale read cannot pass
  always @(drv_oe_b_in, drv_in, host_oe_in, host_d_in) begin
    if (!drv_oe_b_in) bus_out = drv_in;
    else if (host_oe_in) bus_out = host_d_in;
    else bus_out = ~bus_out;
  end
endmodule

/* File: verif/abhp_port_props.sv */
/*
  checker for the converter host port: strobe to output timing, bus float,
  byte layout, done flag and acquisition and conversion lengths.
  assumes the 3-cycle pin latency and the 5-cycle on-chip tick of the port.
*/
`timescale 1ns/10ps
module abhp_port_chk
  import abhp_pkg::*;
#(
  parameter int unsigned CONV_CNT = abhp_pkg::CONV_CLOCKS // converter clocks per conversion
) (
  input wire logic                       clk_sys_in,
  input wire logic                       rst_b_in,
  input wire logic                       cs_b_in,
  input wire logic                       rd_b_in,
  input wire logic                       wr_b_in,
  input wire logic                       high_byte_select_in,
  input wire logic                       ext_clock_mode_in,
  input wire logic [abhp_pkg::BUS_W-1:0] data_out,
  input wire logic                       data_oe_b_out,
  input wire logic                       done_b_out,
  input wire logic                       done_oe_b_out,
  input wire logic [abhp_pkg::BUS_W-1:0] control_byte_out,
  input wire logic                       sampling_out,
  input wire logic                       converting_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  logic [7:0] conv_cnt_q; // cycles spent converting
  logic [7:0] acq_cnt_q;  // cycles spent acquiring
  logic       acq_ext_q;  // current acquisition is host-timed
  // run lengths; mode taken one cycle in so the new byte has landed
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conv_cnt_q <= 8'h00;
      acq_cnt_q  <= 8'h00;
      acq_ext_q  <= 1'b0;
    end else begin
      conv_cnt_q <= converting_out ? conv_cnt_q + 8'h01 : 8'h00;
      acq_cnt_q  <= sampling_out ? acq_cnt_q + 8'h01 : 8'h00;
      if (acq_cnt_q == 8'h01)
        acq_ext_q <= control_byte_out[ACQ_MODE_POS];
    end
  end
  property p_oe; !data_oe_b_out |-> !$past(cs_b_in, 3) && !$past(rd_b_in, 3); endproperty
  a_oe: assert property (p_oe) else $error("bus driven without select and read");
  property p_flt; $past(cs_b_in, 3) |-> done_oe_b_out && data_oe_b_out; endproperty
  a_flt: assert property (p_flt) else $error("outputs driven while deselected");
  property p_hb;
    !data_oe_b_out && $past(high_byte_select_in, 2) && $past(high_byte_select_in, 4)
      |-> data_out[7:2] == 6'h00;
  endproperty
  a_hb: assert property (p_hb) else $error("upper byte lines not clear");
  property p_cnv;
    $fell(converting_out) && !sampling_out && !ext_clock_mode_in
      |-> conv_cnt_q >= CONV_CNT * ONCHIP_DIV - 5 && conv_cnt_q <= CONV_CNT * ONCHIP_DIV + 1;
  endproperty
  a_cnv: assert property (p_cnv) else $error("conversion length wrong");
  property p_dn; $fell(converting_out) && !sampling_out |-> ##[0:2] !done_b_out; endproperty
  a_dn: assert property (p_dn) else $error("done not flagged");
  property p_rdc; !done_b_out && !cs_b_in && $fell(rd_b_in) |-> ##[1:5] done_b_out; endproperty
  a_rdc: assert property (p_rdc) else $error("read did not clear done");
  property p_wr;
    $rose(wr_b_in) && !cs_b_in && !sampling_out
      |-> ##[2:4] sampling_out && done_b_out && !converting_out;
  endproperty
  a_wr: assert property (p_wr) else $error("write did not start acquisition");
  property p_ext;
    $rose(wr_b_in) && !cs_b_in && sampling_out && acq_ext_q |-> ##[2:4] converting_out;
  endproperty
  a_ext: assert property (p_ext) else $error("write did not end acquisition");
  property p_acq;
    $fell(sampling_out) && !acq_ext_q && !ext_clock_mode_in
      |-> converting_out && acq_cnt_q >= ACQ_INT_CYCLES - 1 && acq_cnt_q <= ACQ_INT_CYCLES + 1;
  endproperty
  a_acq: assert property (p_acq) else $error("internal acquisition length wrong");
endmodule

/* File: verif/test_abhp_port.sv */
/*
  testbench of the converter host port: float, internal and host-timed
  acquisition, abort and byte reads. assumes the host model beside it.
*/
`timescale 1ns/10ps
module test_abhp_port;
  logic       clk_sys_in = 1'b0;    // 40 MHz bench clock
  logic       rst_b_in   = 1'b0;    // reset, active low
  logic       cs_b       = 1'b1;    // chip select pin
  logic       rd_b       = 1'b1;    // read strobe pin
  logic       wr_b       = 1'b1;    // write strobe pin
  logic       hbs        = 1'b0;    // high byte select pin
  logic       ext_mode   = 1'b0;    // converter clock from the pin
  logic       host_oe    = 1'b0;    // host drives the bus
  logic [7:0] host_d     = 8'h00;   // host bus value
  logic [9:0] res        = 10'h2a5; // value offered by the sar core
  logic       pin;                  // converter clock pin
  logic       oe_b;                 // port bus enable, low drives
  logic       done_b;               // done level
  logic       done_oe_b;            // done enable, low drives
  logic       samp;                 // acquisition running
  logic       conv;                 // conversion running
  logic [7:0] bus;                  // resolved bus level
  logic [7:0] dout;                 // port bus value
  logic [7:0] ctl;                  // latched control byte
  int         n_errors  = 0;        // mismatches
  int         cmp_count = 0;        // comparisons made
  int         n;                    // cycles waited
  // free-running clock, 25 ns period
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  abhp_host_model u_host (
    .ext_mode_in (ext_mode),
    .drv_oe_b_in (oe_b),
    .drv_in      (dout),
    .host_oe_in  (host_oe),
    .host_d_in   (host_d),
    .clk_pin_out (pin),
    .bus_out     (bus)
  );
  abhp_port DUT (
    .clk_sys_in          (clk_sys_in),
    .rst_b_in            (rst_b_in),
    .cs_b_in             (cs_b),
    .rd_b_in             (rd_b),
    .wr_b_in             (wr_b),
    .high_byte_select_in (hbs),
    .conv_clk_pin_in     (pin),
    .ext_clock_mode_in   (ext_mode),
    .data_in             (bus),
    .result_in           (res),
    .data_out            (dout),
    .data_oe_b_out       (oe_b),
    .done_b_out          (done_b),
    .done_oe_b_out       (done_oe_b),
    .control_byte_out    (ctl),
    .sampling_out        (samp),
    .converting_out      (conv)
  );
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // wait k falling edges; every input moves there
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys_in);
  endtask
  // each strobe and select level lasts 3 cycles or more so the synchronisers see it
  task automatic wr_byte(input logic [7:0] b);
    cs_b    = 1'b0;
    host_d  = b;
    host_oe = 1'b1;
    cyc(4);
    wr_b = 1'b0;
    cyc(4);
    wr_b = 1'b1;
    cyc(4);
    host_oe = 1'b0;
    cs_b    = 1'b1;
    cyc(3);
  endtask
  task automatic rd_byte(input logic h, input logic [7:0] exp);
    cs_b = 1'b0;
    hbs  = h;
    cyc(4);
    rd_b = 1'b0;
    cyc(4);
    chk("bus_oe", 8'h00, {7'h00, oe_b});
    chk("done_oe", 8'h00, {7'h00, done_oe_b});
    chk("bus_data", exp, bus);
    rd_b = 1'b1;
    cyc(4);
    chk("bus_rel", 8'h01, {7'h00, oe_b});
    cs_b = 1'b1;
    cyc(3);
  endtask
  // bounded wait for done; n ends as the cycles spent
  task automatic wait_done;
    for (n = 0; n < 400 && done_b !== 1'b0; n++) begin
      cyc(1);
    end
  endtask
  task automatic t_float;
    rd_b = 1'b0;
    cyc(5);
    chk("float", 8'h03, {6'h00, oe_b, done_oe_b});
    rd_b = 1'b1;
    cyc(4);
  endtask
  task automatic t_internal;
    wr_byte(8'h00);
    wait_done;
    chk("int_time", 8'h01, {7'h00, n >= 96 && n <= 112});
    chk("done", 8'h00, {7'h00, done_b});
    rd_byte(1'b0, 8'ha5);
    chk("done_rd", 8'h01, {7'h00, done_b});
    rd_byte(1'b1, 8'h02);
  endtask
  task automatic t_abort;
    wr_byte(8'h00);
    for (n = 0; n < 100 && conv !== 1'b1; n++) begin
      cyc(1);
    end
    cyc(10);
    wr_byte(8'h00);
    chk("abort", 8'h02, {6'h00, samp, conv});
    wait_done;
    chk("restart", 8'h01, {7'h00, n >= 96 && n <= 112});
  endtask
  // pin clock of 160 ns: host-timed acquisition, then internal acquisition of three clocks
  task automatic t_external;
    ext_mode = 1'b1;
    wr_byte(8'h20);
    chk("done_wr", 8'h01, {7'h00, done_b});
    chk("ctl", 8'h20, ctl);
    cyc(60);
    chk("ext_hold", 8'h02, {6'h00, samp, conv});
    res = 10'h15a;
    wr_byte(8'h00);
    chk("ext_end", 8'h01, {6'h00, samp, conv});
    wait_done;
    chk("ext_time", 8'h01, {7'h00, n >= 70 && n <= 90});
    rd_byte(1'b0, 8'h5a);
    rd_byte(1'b1, 8'h01);
    wr_byte(8'h00);
    wait_done;
    chk("ext_int_time", 8'h01, {7'h00, n >= 86 && n <= 108});
    ext_mode = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // reset for four cycles, then the scenarios in order
  initial begin
    cyc(4);
    rst_b_in = 1'b1;
    cyc(6);
    t_float;
    t_internal;
    t_abort;
    t_external;
    tally_and_finish;
  end
  // watchdog: the scenarios need about 650 cycles
  initial begin
    cyc(4000);
    n_errors++;
    tally_and_finish;
  end
endmodule
bind abhp_port abhp_port_chk #(.CONV_CNT(CONV_CNT)) u_chk (
  .clk_sys_in          (clk_sys_in),
  .rst_b_in            (rst_b_in),
  .cs_b_in             (cs_b_in),
  .rd_b_in             (rd_b_in),
  .wr_b_in             (wr_b_in),
  .high_byte_select_in (high_byte_select_in),
  .ext_clock_mode_in   (ext_clock_mode_in),
  .data_out            (data_out),
  .data_oe_b_out       (data_oe_b_out),
  .done_b_out          (done_b_out),
  .done_oe_b_out       (done_oe_b_out),
  .control_byte_out    (control_byte_out),
  .sampling_out        (sampling_out),
  .converting_out      (converting_out)
);
